// ===== shc_map.vh
// register map, field positions, reset values and timing counts of the handler control block
//
// Behaviour
// - writing one to reset-request bit 2 asserts the system reset request output
// - the reset request causes warm reset, which returns the reset-request bit to zero
// - clear-active bit erases all active state; zero does nothing; bit self-clears
// - local reset bit 0 resets all but debug units and reads back zero
// - byte order flag reads zero: little-endian is the default
// - each system exception owns one 8-bit priority slot, four per word
// - three priority words at consecutive addresses hold slots 4-7, 8-11, 12-15
// - only the top three bits of each slot are implemented
// - unimplemented slot bits read zero and writes to them are ignored
// - first word: memmanage 7-5, bus 15-13, usage 23-21, 31-29 reserved writable
// - control word: fault enables 18-16, pending bits 15-12, zero after reset
// - active bits 11,10,8,7,3,1,0 read/write; writes change state only
// - writes need key 0x5fa in bits 31-16; reads return 0xfa05
`ifndef SHC_MAP_VH
`define SHC_MAP_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define SHC_ADDR_PRI_FAULT   32'he000ed18
`define SHC_ADDR_PRI_CALL    32'he000ed1c
`define SHC_ADDR_PRI_TICK    32'he000ed20
`define SHC_ADDR_CTRL_STATE  32'he000ed24
`define SHC_ADDR_APP_RESET   32'he000ed0c
`define SHC_ADDR_IRQ_STATUS  32'he000ed80
`define SHC_ADDR_IRQ_ENABLE  32'he000ed84
`define SHC_ADDR_IRQ_CLEAR   32'he000ed88

// ****************************************************************
// field positions and masks
// ****************************************************************
`define SHC_PRI_MASK         32'he0e0e0e0
`define SHC_CTRL_MASK        32'h0007fd8b
`define SHC_CTRL_ACTIVE_MASK 32'h00000d8b
`define SHC_APP_SYSREQ_BIT   2
`define SHC_APP_CLRACT_BIT   1
`define SHC_APP_LOCRST_BIT   0
`define SHC_APP_ORDER_BIT    15
`define SHC_KEY_WRITE        16'h05fa
`define SHC_KEY_READ         16'hfa05

// ****************************************************************
// reset values and event bits
// ****************************************************************
`define SHC_PRI_RESET        32'h00000000
`define SHC_CTRL_RESET       32'h00000000
`define SHC_EVT_SYSREQ       0
`define SHC_EVT_CLRACT       1
`define SHC_EVT_LOCRST       2
`define SHC_EVT_BADKEY       3
`define SHC_EVT_WIDTH        4

// ****************************************************************
// timing
// ****************************************************************
`define SHC_CLK_HZ           10000000
`define SHC_PULSE_NS         100
`define SHC_PULSE_CYC        ((`SHC_PULSE_NS * (`SHC_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ===== shc_event_reg.v
// sticky event status, enable and interrupt level
`timescale 1ns/10ps
`include "shc_map.vh"
module shc_event_reg #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             sys_clk_in,
  input  wire             rst_b_in,
  // events and software access
  input  wire [WIDTH-1:0] event_in,
  input  wire [WIDTH-1:0] clear_in,
  input  wire [WIDTH-1:0] enable_in,
  // results
  output reg  [WIDTH-1:0] status_out,
  output reg              irq_out
);
  wire [WIDTH-1:0] next_status;
  genvar i;

  // ****************************************************************
  // sticky bits: a set in the clearing cycle wins
  // ****************************************************************
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign next_status[i] = event_in[i] | (status_out[i] & ~clear_in[i]);
    end
  endgenerate

  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_out <= {WIDTH{1'b0}};
      irq_out    <= 1'b0;
    end else begin
      status_out <= next_status;
      irq_out    <= |(next_status & enable_in);
    end
  end
endmodule

// ===== shc_top.v
// handler priority, control/state and application reset control registers on wishbone
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
`include "shc_map.vh"
module shc_top #(
  parameter PULSE_CYC = `SHC_PULSE_CYC
) (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_b_in,
  // wishbone slave
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [31:0] wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // reset and exception control
  output reg         system_reset_request_out,
  output reg         local_system_reset_out,
  output reg         clear_active_exception_state_out,
  // fault enables and priorities to the exception logic
  output reg         usage_fault_enable_out,
  output reg         bus_fault_enable_out,
  output reg         memmanage_fault_enable_out,
  output reg  [2:0]  memmanage_priority_out,
  output reg  [2:0]  bus_fault_priority_out,
  output reg  [2:0]  usage_fault_priority_out,
  // interrupt
  output wire        irq_out
);
  // ****************************************************************
  // storage
  // ****************************************************************
  reg  [31:0] pri_reg [0:2];
  reg  [31:0] ctrl_state;
  reg  [3:0]  irq_enable;
  reg  [3:0]  evt_pulse;
  reg  [3:0]  evt_clear;
  reg  [7:0]  pulse_cnt;
  reg         sys_req;
  wire [3:0]  irq_status;
  wire [31:0] byte_mask;
  wire [31:0] next_pri;
  wire [31:0] next_ctrl;
  wire        wr_req;
  wire        key_ok;
  reg  [31:0] next_rdata;
  reg         hit;
  integer     k;

  function [1:0] pri_index;
    input [31:0] adr;
    begin
      if (adr == `SHC_ADDR_PRI_FAULT)
        pri_index = 2'd0;
      else if (adr == `SHC_ADDR_PRI_CALL)
        pri_index = 2'd1;
      else if (adr == `SHC_ADDR_PRI_TICK)
        pri_index = 2'd2;
      else
        pri_index = 2'd3;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdata;
    input [31:0] lanes;
    input [31:0] impl;
    begin
      merge = ((old & ~lanes) | (wdata & lanes)) & impl;
    end
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign byte_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wr_req    = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out;
  assign key_ok    = (wb_dat_in[31:16] == `SHC_KEY_WRITE) & wb_sel_in[3] & wb_sel_in[2];
  assign next_ctrl = merge(ctrl_state, wb_dat_in, byte_mask, `SHC_CTRL_MASK);
  assign next_pri  = merge(pri_reg[pri_index(wb_adr_in)], wb_dat_in, byte_mask,
                           `SHC_PRI_MASK);

  always @* begin
    hit        = 1'b1;
    next_rdata = 32'h00000000;
    case (wb_adr_in)
      `SHC_ADDR_PRI_FAULT,
      `SHC_ADDR_PRI_CALL,
      `SHC_ADDR_PRI_TICK:   next_rdata = pri_reg[pri_index(wb_adr_in)] & `SHC_PRI_MASK;
      `SHC_ADDR_CTRL_STATE: next_rdata = ctrl_state;
      `SHC_ADDR_APP_RESET:  next_rdata = {`SHC_KEY_READ, 16'h0000};
      `SHC_ADDR_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
      `SHC_ADDR_IRQ_ENABLE: next_rdata = {28'h0000000, irq_enable};
      `SHC_ADDR_IRQ_CLEAR:  next_rdata = 32'h00000000;
      default:              hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // register writes and one-cycle ack
  // ****************************************************************
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (k = 0; k < 3; k = k + 1)
        pri_reg[k] <= `SHC_PRI_RESET;
      ctrl_state <= `SHC_CTRL_RESET;
      irq_enable <= 4'h0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
      evt_pulse  <= 4'h0;
      evt_clear  <= 4'h0;
      sys_req    <= 1'b0;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      wb_dat_out <= (wb_cyc_in & wb_stb_in & ~wb_we_in & hit) ? next_rdata : 32'h00000000;
      evt_pulse  <= 4'h0;
      evt_clear  <= 4'h0;
      if (sys_req)
        sys_req <= 1'b0;
      if (wr_req) begin
        case (wb_adr_in)
          `SHC_ADDR_PRI_FAULT,
          `SHC_ADDR_PRI_CALL,
          `SHC_ADDR_PRI_TICK:   pri_reg[pri_index(wb_adr_in)] <= next_pri;
          `SHC_ADDR_CTRL_STATE: ctrl_state <= next_ctrl;
          `SHC_ADDR_APP_RESET: begin
            if (key_ok & wb_sel_in[0]) begin
              if (wb_dat_in[`SHC_APP_SYSREQ_BIT]) begin
                sys_req                    <= 1'b1;
                evt_pulse[`SHC_EVT_SYSREQ] <= 1'b1;
              end
              if (wb_dat_in[`SHC_APP_CLRACT_BIT]) begin
                ctrl_state                 <= ctrl_state & ~`SHC_CTRL_ACTIVE_MASK;
                evt_pulse[`SHC_EVT_CLRACT] <= 1'b1;
              end
              if (wb_dat_in[`SHC_APP_LOCRST_BIT]) begin
                for (k = 0; k < 3; k = k + 1)
                  pri_reg[k] <= `SHC_PRI_RESET;
                ctrl_state                 <= `SHC_CTRL_RESET;
                evt_pulse[`SHC_EVT_LOCRST] <= 1'b1;
              end
            end else begin
              evt_pulse[`SHC_EVT_BADKEY] <= 1'b1;
            end
          end
          `SHC_ADDR_IRQ_ENABLE: if (wb_sel_in[0]) irq_enable <= wb_dat_in[3:0];
          `SHC_ADDR_IRQ_CLEAR:  if (wb_sel_in[0]) evt_clear <= wb_dat_in[3:0];
          default:              irq_enable <= irq_enable;
        endcase
      end
    end
  end

  // ****************************************************************
  // reset and clear pulses, held for the pulse width
  // ****************************************************************
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pulse_cnt                        <= 8'h00;
      system_reset_request_out         <= 1'b0;
      local_system_reset_out           <= 1'b0;
      clear_active_exception_state_out <= 1'b0;
    end else begin
      // the request is a pulse; the warm reset it triggers clears this block anyway
      if (evt_pulse[2:0] != 3'b000) begin
        pulse_cnt                        <= PULSE_CYC[7:0];
        system_reset_request_out         <= evt_pulse[`SHC_EVT_SYSREQ] | system_reset_request_out;
        local_system_reset_out           <= evt_pulse[`SHC_EVT_LOCRST] | local_system_reset_out;
        clear_active_exception_state_out <= evt_pulse[`SHC_EVT_CLRACT]
                                            | clear_active_exception_state_out;
      end else if (pulse_cnt > 8'h01) begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end else begin
        pulse_cnt                        <= 8'h00;
        system_reset_request_out         <= 1'b0;
        local_system_reset_out           <= 1'b0;
        clear_active_exception_state_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // decoded fields to the exception logic
  // ****************************************************************
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      usage_fault_enable_out     <= 1'b0;
      bus_fault_enable_out       <= 1'b0;
      memmanage_fault_enable_out <= 1'b0;
      memmanage_priority_out     <= 3'h0;
      bus_fault_priority_out     <= 3'h0;
      usage_fault_priority_out   <= 3'h0;
    end else begin
      usage_fault_enable_out     <= ctrl_state[18];
      bus_fault_enable_out       <= ctrl_state[17];
      memmanage_fault_enable_out <= ctrl_state[16];
      memmanage_priority_out     <= pri_reg[0][7:5];
      bus_fault_priority_out     <= pri_reg[0][15:13];
      usage_fault_priority_out   <= pri_reg[0][23:21];
    end
  end

  shc_event_reg #(
    .WIDTH (`SHC_EVT_WIDTH)
  ) u_events (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .event_in   (evt_pulse),
    .clear_in   (evt_clear),
    .enable_in  (irq_enable),
    .status_out (irq_status),
    .irq_out    (irq_out)
  );
endmodule

// ===== shc_top_props.sv
// concurrent checks on the bus answer and control pulses of the handler control block
`timescale 1ns/10ps
module shc_top_props #(
  parameter PULSE_CYC = 1
) (
  // clock and reset
  input wire        sys_clk_in,
  input wire        rst_b_in,
  // wishbone slave
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire [31:0] wb_adr_in,
  input wire [3:0]  wb_sel_in,
  input wire [31:0] wb_dat_in,
  input wire [31:0] wb_dat_out,
  input wire        wb_ack_out,
  // control pulses
  input wire        system_reset_request_out,
  input wire        local_system_reset_out,
  input wire        clear_active_exception_state_out
);
  // ****************************************************************
  // sequences
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire key_ok = wb_dat_in[31:16] == 16'h05fa;
  wire rd_ack = wb_ack_out && !wb_we_in;
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_app_wr;
    s_take ##0 (wb_we_in && wb_adr_in == 32'he000ed0c && wb_sel_in == 4'hf);
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_ack_next_cycle: assert property (s_take |=> wb_ack_out) else $error("ack late");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_reset_request: assert property (s_app_wr ##0 (key_ok && wb_dat_in[2]) |->
    ##[1:2] system_reset_request_out) else $error("no reset request");
  a_clear_active: assert property (s_app_wr ##0 (key_ok && wb_dat_in[1]) |->
    ##[1:2] clear_active_exception_state_out) else $error("no clear pulse");
  a_local_reset: assert property (s_app_wr ##0 (key_ok && wb_dat_in[0]) |->
    ##[1:2] local_system_reset_out) else $error("no local reset");
  a_bad_key: assert property (s_app_wr ##0 !key_ok |=>
    !(system_reset_request_out || local_system_reset_out)[*3]) else $error("bad key obeyed");
  a_key_readback: assert property (rd_ack && wb_adr_in == 32'he000ed0c |->
    wb_dat_out == 32'hfa050000) else $error("app read wrong");
  a_pri_unused: assert property (rd_ack && wb_adr_in >= 32'he000ed18 &&
    wb_adr_in <= 32'he000ed20 |-> (wb_dat_out & 32'h1f1f1f1f) == 0) else $error("pri bits");
  a_ctrl_unused: assert property (rd_ack && wb_adr_in == 32'he000ed24 |->
    (wb_dat_out & 32'hfff80274) == 0) else $error("ctrl bits");
endmodule

bind shc_top shc_top_props #(.PULSE_CYC(PULSE_CYC)) u_props (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .system_reset_request_out(system_reset_request_out),
  .local_system_reset_out(local_system_reset_out),
  .clear_active_exception_state_out(clear_active_exception_state_out));

// ===== tb_system_handler_control.sv
// self-checking bench of the handler control block against a register model
`timescale 1ns/10ps
`include "shc_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_system_handler_control;
  reg         sys_clk_in, rst_b_in, cyc, stb, we;
  reg  [31:0] adr, wdat, q, d, lm;
  reg  [3:0]  sel, s;
  wire [31:0] rdat;
  wire        ack, sreq, lrst, clr, ue, be, me, irq;
  wire [2:0]  mp, bp, up;
  reg  [31:0] pri [0:2];
  reg  [31:0] ctrl, stat;
  integer     error_cnt, cmp_count, seed, cycles, i, k, sreq_cnt;
  shc_top #(.PULSE_CYC(1)) u_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .system_reset_request_out(sreq),
    .local_system_reset_out(lrst), .clear_active_exception_state_out(clr),
    .usage_fault_enable_out(ue), .bus_fault_enable_out(be), .memmanage_fault_enable_out(me),
    .memmanage_priority_out(mp), .bus_fault_priority_out(bp), .usage_fault_priority_out(up),
    .irq_out(irq));
  initial begin
    sys_clk_in = 0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // ****************************************************************
  // bus cycle, monitor and verdict
  // ****************************************************************
  task wb(input [31:0] a, input w, input [31:0] dv, input [3:0] sv);
    integer n;
    begin
      n = 0;
      @(posedge sys_clk_in);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= dv; sel <= sv;
      do begin @(posedge sys_clk_in); n++; end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 0; stb <= 0; we <= 0;
      if (n >= 50) `CHK(1'b0, 1'b1)
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // a request pulse is one cycle long, so its high cycles count the requests
  always @(posedge sys_clk_in) begin
    cycles++;
    if (sreq === 1'b1) sreq_cnt++;
    if (cycles == 20000) begin error_cnt++; results; end
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    error_cnt = 0; cmp_count = 0; seed = 85708; cycles = 0; sreq_cnt = 0; rst_b_in = 0;
    cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; sel = 0; ctrl = 0; stat = 0;
    for (i = 0; i < 3; i++) pri[i] = 0;
    repeat (16) @(posedge sys_clk_in);
    rst_b_in <= 1;
    for (i = 0; i < 5; i++) begin
      wb(`SHC_ADDR_PRI_FAULT + 4 * i, 0, 0, 4'hf);
      `CHK(q, 32'h0)
    end
    wb(`SHC_ADDR_APP_RESET, 0, 0, 4'hf);
    `CHK(q, 32'hfa050000)
    wb(32'he000ee00, 0, 0, 4'hf);
    `CHK(q, 32'h0)
    $display("test reset values done");
    for (i = 0; i < 24; i++) begin
      k = i % 4; d = $random(seed); s = $random(seed);
      lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wb(`SHC_ADDR_PRI_FAULT + 4 * k, 1, d, s);
      if (k < 3) pri[k] = ((pri[k] & ~lm) | (d & lm)) & `SHC_PRI_MASK;
      else ctrl = ((ctrl & ~lm) | (d & lm)) & `SHC_CTRL_MASK;
      wb(`SHC_ADDR_PRI_FAULT + 4 * k, 0, 0, 4'hf);
      `CHK(q, (k < 3) ? pri[k] : ctrl)
    end
    repeat (2) @(posedge sys_clk_in);
    #1 `CHK({up, bp, mp}, {pri[0][23:21], pri[0][15:13], pri[0][7:5]})
    `CHK({ue, be, me}, ctrl[18:16])
    $display("test random registers done");
    wb(`SHC_ADDR_CTRL_STATE, 1, 32'hffffffff, 4'hf);
    wb(`SHC_ADDR_APP_RESET, 1, 32'h05fa0002, 4'hf);
    stat[1] = 1;
    wb(`SHC_ADDR_CTRL_STATE, 0, 0, 4'hf);
    `CHK(q, `SHC_CTRL_MASK & ~`SHC_CTRL_ACTIVE_MASK)
    repeat (3) @(posedge sys_clk_in);
    wb(`SHC_ADDR_APP_RESET, 1, 32'h05fb0004, 4'hf);
    stat[3] = 1;
    repeat (4) @(posedge sys_clk_in);
    `CHK(sreq_cnt, 0)
    wb(`SHC_ADDR_APP_RESET, 1, 32'h05fa0004, 4'hf);
    stat[0] = 1;
    repeat (4) @(posedge sys_clk_in);
    `CHK(sreq_cnt, 1)
    wb(`SHC_ADDR_APP_RESET, 0, 0, 4'hf);
    `CHK(q, 32'hfa050000)
    wb(`SHC_ADDR_APP_RESET, 1, 32'h05fa0001, 4'hf);
    stat[2] = 1;
    for (i = 0; i < 4; i++) begin
      wb(`SHC_ADDR_PRI_FAULT + 4 * i, 0, 0, 4'hf);
      `CHK(q, 32'h0)
    end
    $display("test application control done");
    wb(`SHC_ADDR_IRQ_STATUS, 0, 0, 4'hf);
    `CHK(q[3:0], stat[3:0])
    wb(`SHC_ADDR_IRQ_ENABLE, 1, 32'h8, 4'hf);
    repeat (2) @(posedge sys_clk_in);
    #1 `CHK(irq, 1'b1)
    wb(`SHC_ADDR_IRQ_CLEAR, 1, 32'h8, 4'hf);
    repeat (2) @(posedge sys_clk_in);
    #1 `CHK(irq, 1'b0)
    wb(`SHC_ADDR_IRQ_STATUS, 0, 0, 4'hf);
    `CHK(q[3:0], 4'h7)
    $display("test interrupt done");
    results;
  end
endmodule
